// ===== rtl/fscx_pkg.sv
// Constants, types and helpers of the fail-safe clock exit block
// Operation
// - Fail-safe state ends only on reset or power-managed entry; otherwise it holds.
// - After reset, start the configured primary source with its start-up delay.
// - While the primary source starts, the system runs on the internal oscillator.
// - When primary is ready, switch to it and set the running flag.
// - After that switch the monitor resumes checking the primary clock.
// - If the primary source never gets ready, stay on the internal oscillator.
// - In that case the oscillator control register keeps its reset value.
// - Writing the control register then the sleep instruction clears fail-safe.
// - Clearing fail-safe via power-managed entry lets the monitor resume.
// - Sample clock is internal RC divided by 64; latch set/cleared by edges.
// - Failure when a sample clock falling edge finds the latch still set.
// - On failure set the fail flag, use internal clock, keep control register.
// - A failure also resets the watchdog counter and its postscaler; the block only gives a one-cycle watchdog_counter_reset pulse.
package fscx_pkg;

	// Register byte offsets
	localparam logic [7:0] ADDR_OSC_CTRL = 8'h00;
	localparam logic [7:0] ADDR_MON_STAT = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_CLR  = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_EN   = 8'h10;

	// Oscillator control register layout
	localparam int         OSC_SCS_LSB   = 0;
	localparam int         OSC_RUN_BIT   = 3;
	localparam int         OSC_IRCF_LSB  = 4;
	localparam logic [7:0] OSC_CTRL_RST  = 8'h00;
	localparam logic [7:0] OSC_WR_MASK   = 8'h73;

	// Interrupt status layout
	localparam int         IRQ_FAIL_BIT  = 0;
	localparam int         IRQ_READY_BIT = 1;
	localparam logic [1:0] IRQ_RST       = 2'h0;

	// Primary oscillator modes from configuration
	localparam logic [1:0] MODE_EC       = 2'h0;
	localparam logic [1:0] MODE_XT       = 2'h1;
	localparam logic [1:0] MODE_XT_PLL   = 2'h2;

	// Timing
	localparam int         SAMPLE_DIV    = 64;
	localparam int         OST_EDGES     = 1024;
	localparam int         CLK_PERIOD_NS = 40;
	localparam int         PLL_LOCK_NS   = 100000;
	localparam int         PLL_LOCK_CYC  =
		(PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		ST_START,
		ST_PRIMARY,
		ST_FAILSAFE,
		ST_INTERNAL
	} fscx_state_t;

	function automatic logic fscx_fall(input logic prev, input logic cur);
		return prev & ~cur;
	endfunction : fscx_fall

	function automatic logic fscx_rise(input logic prev, input logic cur);
		return ~prev & cur;
	endfunction : fscx_rise

	function automatic logic fscx_wants_primary(input logic [7:0] ctrl);
		return ctrl[OSC_SCS_LSB +: 2] == 2'h0;
	endfunction : fscx_wants_primary

endpackage : fscx_pkg

// ===== rtl/fscx_clk_switch.sv
// Break-before-make system clock multiplexer
`timescale 1ns/1ns
module fscx_clk_switch
	import fscx_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Source levels
	input  wire logic primary_clk,
	input  wire logic internal_oscillator_clock,
	// Control
	input  wire logic sel_primary,
	input  wire logic force_off,
	// Result
	output logic      sys_clk,
	output logic      on_primary
);

	logic en_p_q;
	logic en_i_q;

	// Old gate drops only while its clock is low (primary also on force_off), new gate rises only
	// when both are off and its own clock is low
	always_ff @(posedge clk) begin
		if (rst) begin
			en_p_q <= 1'b0;
			en_i_q <= 1'b1;
		end else if (sel_primary) begin
			if (en_i_q && !internal_oscillator_clock)
				en_i_q <= 1'b0;
			else if (!en_i_q && !en_p_q && !primary_clk)
				en_p_q <= 1'b1;
		end else begin
			// A dead primary may never go low, so a failure cuts it at once
			if (en_p_q && (force_off || !primary_clk))
				en_p_q <= 1'b0;
			else if (!en_p_q && !en_i_q && !internal_oscillator_clock)
				en_i_q <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			sys_clk <= 1'b0;
		else
			sys_clk <= (primary_clk & en_p_q) |
				(internal_oscillator_clock & en_i_q);
	end

	assign on_primary = en_p_q;

	AST_NO_OVERLAP: assert property (@(posedge clk) disable iff (rst)
		!(en_p_q && en_i_q))
		else $error("both clock gates open");

endmodule : fscx_clk_switch

// ===== rtl/fscx_top.sv
// Fail-safe clock exit, start-up, monitor and register slave
//
// The register addresses and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ns
module fscx_top
	import fscx_pkg::*;
#(
	parameter int OST_COUNT  = OST_EDGES,
	parameter int PLL_CYCLES = PLL_LOCK_CYC
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Wishbone slave
	input  wire logic        wb_cyc,
	input  wire logic        wb_stb,
	input  wire logic        wb_we,
	input  wire logic [7:0]  wb_adr,
	input  wire logic [3:0]  wb_sel,
	input  wire logic [31:0] wb_dat_w,
	output logic      [31:0] wb_dat_r,
	output logic             wb_ack,
	// Clock source levels
	input  wire logic        primary_clk,
	input  wire logic        internal_oscillator_clock,
	input  wire logic        internal_rc_clock,
	// Configuration
	input  wire logic [1:0]  cfg_osc_mode,
	input  wire logic        cfg_monitor_en,
	// Core events
	input  wire logic        sleep_exec,
	input  wire logic        wake,
	// Outputs
	output logic             sys_clk,
	output logic             on_primary,
	output logic             power_managed,
	output logic             watchdog_counter_reset,
	output logic             irq
);

	fscx_state_t state_q;
	logic [7:0]  oscillator_control_register_q;
	logic [10:0] ost_cnt_q;
	logic [15:0] pll_cnt_q;
	logic        ost_done_q;
	logic        pll_done_q;
	logic        prim_prev_q;
	logic        rc_prev_q;
	logic [5:0]  div_q;
	logic        clock_monitor_latch_q;
	logic [1:0]  irq_stat_q;
	logic [1:0]  irq_en_q;
	logic        wdt_rst_q;
	logic        pm_q;
	logic        ack_q;
	logic [31:0] rdata_q;

	logic prim_fall;
	logic rc_rise;
	logic sample_rise;
	logic sample_fall;
	logic primary_ready;
	logic mon_active;
	logic fail_det;
	logic wb_req;
	logic wb_wr;
	logic osc_wr;
	logic restart;
	logic wants_primary;
	logic keep_primary;

	assign prim_fall   = fscx_fall(prim_prev_q, primary_clk);
	assign rc_rise     = fscx_rise(rc_prev_q, internal_rc_clock);
	// Sample clock is bit 5 of the divider: high for 32, low for 32
	assign sample_rise = rc_rise && div_q == 6'(SAMPLE_DIV / 2 - 1);
	assign sample_fall = rc_rise && div_q == 6'(SAMPLE_DIV - 1);

	assign wb_req  = wb_cyc && wb_stb;
	assign wb_wr   = wb_req && wb_we && ack_q && wb_sel[0];
	assign osc_wr  = wb_wr && wb_adr == ADDR_OSC_CTRL;
	assign wants_primary = fscx_wants_primary(oscillator_control_register_q);

	// External clock mode needs no delay, crystal modes wait for the
	// start-up timer, the PLL mode also for lock
	always_comb begin
		unique case (cfg_osc_mode)
			MODE_EC:     primary_ready = 1'b1;
			MODE_XT:     primary_ready = ost_done_q;
			MODE_XT_PLL: primary_ready = ost_done_q && pll_done_q;
			default:     primary_ready = ost_done_q;
		endcase
	end

	// Monitoring only makes sense once the system really runs on primary
	assign mon_active = cfg_monitor_en && state_q == ST_PRIMARY &&
		on_primary;
	assign fail_det = mon_active && sample_fall &&
		clock_monitor_latch_q;

	// Power-managed entry from fail-safe or internal that asks for primary restarts the start-up
	assign restart = sleep_exec && wants_primary &&
		state_q != ST_PRIMARY && state_q != ST_START;

	// Select drops in the detecting cycle: a dead primary stuck high
	// would otherwise keep its gate open until it went low
	assign keep_primary = state_q == ST_PRIMARY && !fail_det;

	always_ff @(posedge clk) begin
		if (rst) begin
			prim_prev_q <= 1'b0;
			rc_prev_q   <= 1'b0;
		end else begin
			prim_prev_q <= primary_clk;
			rc_prev_q   <= internal_rc_clock;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			div_q <= 6'h00;
		else if (rc_rise)
			div_q <= div_q + 6'h01;
	end

	// Set by a falling monitored edge, cleared by the rising sample edge;
	// the set wins so a late edge still leaves the latch set, which the falling sample edge reads as a failure
	always_ff @(posedge clk) begin
		if (rst)
			clock_monitor_latch_q <= 1'b0;
		else if (prim_fall)
			clock_monitor_latch_q <= 1'b1;
		else if (sample_rise)
			clock_monitor_latch_q <= 1'b0;
	end

	// Start-up timer counts primary falling edges, then PLL lock cycles
	always_ff @(posedge clk) begin
		if (rst || restart) begin
			ost_cnt_q  <= 11'h000;
			ost_done_q <= 1'b0;
		end else if (state_q == ST_START && !ost_done_q && prim_fall) begin
			if (ost_cnt_q == 11'(OST_COUNT - 1))
				ost_done_q <= 1'b1;
			ost_cnt_q <= ost_cnt_q + 11'h001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || restart) begin
			pll_cnt_q  <= 16'h0000;
			pll_done_q <= 1'b0;
		end else if (state_q == ST_START && ost_done_q && !pll_done_q) begin
			if (pll_cnt_q == 16'(PLL_CYCLES - 1))
				pll_done_q <= 1'b1;
			pll_cnt_q <= pll_cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= ST_START;
		end else begin
			unique case (state_q)
				ST_START: begin
					if (sleep_exec && !wants_primary)
						state_q <= ST_INTERNAL;
					else if (primary_ready && !sleep_exec)
						state_q <= ST_PRIMARY;
					// A never-ready primary leaves us here until a sleep selects internal
				end
				ST_PRIMARY: begin
					if (fail_det)
						state_q <= ST_FAILSAFE;
					else if (sleep_exec && !wants_primary)
						state_q <= ST_INTERNAL;
				end
				ST_FAILSAFE: begin
					// Only power-managed entry leaves; reset is above
					if (sleep_exec)
						state_q <= wants_primary ? ST_START :
							ST_INTERNAL;
				end
				ST_INTERNAL: begin
					if (sleep_exec && wants_primary)
						state_q <= ST_START;
				end
			endcase
		end
	end

	// Running flag is hardware owned; a failure leaves the register alone
	// so it still names primary while the internal clock runs
	always_ff @(posedge clk) begin
		if (rst) begin
			oscillator_control_register_q <= OSC_CTRL_RST;
		end else begin
			if (osc_wr)
				oscillator_control_register_q[6:0] <=
					(wb_dat_w[6:0] & OSC_WR_MASK[6:0]) |
					(oscillator_control_register_q[6:0] & ~OSC_WR_MASK[6:0]);
			if (state_q == ST_START && primary_ready && !sleep_exec)
				oscillator_control_register_q[OSC_RUN_BIT] <= 1'b1;
			else if (sleep_exec && state_q != ST_PRIMARY)
				oscillator_control_register_q[OSC_RUN_BIT] <= 1'b0;
			else if (sleep_exec && !wants_primary)
				oscillator_control_register_q[OSC_RUN_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			wdt_rst_q <= 1'b0;
		else
			wdt_rst_q <= fail_det;
	end

	always_ff @(posedge clk) begin
		if (rst)
			pm_q <= 1'b0;
		else if (sleep_exec)
			pm_q <= 1'b1;
		else if (wake)
			pm_q <= 1'b0;
	end

	// Sticky events; a new event beats a clear in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_stat_q <= IRQ_RST;
		end else begin
			if (wb_wr && wb_adr == ADDR_IRQ_CLR)
				irq_stat_q <= irq_stat_q & ~wb_dat_w[1:0];
			if (fail_det)
				irq_stat_q[IRQ_FAIL_BIT] <= 1'b1;
			if (state_q == ST_START && primary_ready && !sleep_exec)
				irq_stat_q[IRQ_READY_BIT] <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			irq_en_q <= IRQ_RST;
		else if (wb_wr && wb_adr == ADDR_IRQ_EN)
			irq_en_q <= wb_dat_w[1:0];
	end

	// Ack one cycle after the strobe; writes land on the ack edge
	always_ff @(posedge clk) begin
		if (rst)
			ack_q <= 1'b0;
		else
			ack_q <= wb_req && !ack_q;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= 32'h0000_0000;
		end else if (wb_req && !ack_q) begin
			unique case (wb_adr)
				ADDR_OSC_CTRL:
					rdata_q <= {24'h000000, oscillator_control_register_q};
				ADDR_MON_STAT:
					rdata_q <= {28'h0000000, clock_monitor_latch_q,
						on_primary, primary_ready,
						state_q == ST_FAILSAFE};
				ADDR_IRQ_STAT:
					rdata_q <= {30'h0, irq_stat_q};
				ADDR_IRQ_EN:
					rdata_q <= {30'h0, irq_en_q};
				default:
					rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	fscx_clk_switch u_switch (
		.clk                       (clk),
		.rst                       (rst),
		.primary_clk               (primary_clk),
		.internal_oscillator_clock (internal_oscillator_clock),
		.sel_primary               (keep_primary),
		.force_off                 (fail_det),
		.sys_clk                   (sys_clk),
		.on_primary                (on_primary)
	);

	assign wb_ack                 = ack_q;
	assign wb_dat_r               = rdata_q;
	assign power_managed          = pm_q;
	assign watchdog_counter_reset = wdt_rst_q;
	assign irq                    = |(irq_stat_q & irq_en_q);

	AST_FS_HOLD: assert property (@(posedge clk) disable iff (rst)
		state_q == ST_FAILSAFE && !sleep_exec |=> state_q == ST_FAILSAFE)
		else $error("fail-safe left without sleep");

	AST_START_ON_INT: assert property (@(posedge clk) disable iff (rst)
		state_q == ST_START |-> !on_primary)
		else $error("primary gated during start-up");

	AST_READY_SWITCH: assert property (@(posedge clk) disable iff (rst)
		state_q == ST_START && primary_ready && !sleep_exec |=>
		state_q == ST_PRIMARY && oscillator_control_register_q[OSC_RUN_BIT])
		else $error("ready primary not taken");

	AST_MON_AFTER_SW: assert property (@(posedge clk) disable iff (rst)
		state_q == ST_PRIMARY && on_primary && cfg_monitor_en &&
		sample_fall && clock_monitor_latch_q |=> state_q == ST_FAILSAFE)
		else $error("monitor idle after switch to primary");

	AST_NEVER_READY: assert property (@(posedge clk) disable iff (rst)
		state_q == ST_START && !primary_ready && !sleep_exec |=>
		state_q == ST_START)
		else $error("left start without ready primary");

	AST_CTRL_KEPT: assert property (@(posedge clk) disable iff (rst)
		state_q == ST_START && !primary_ready && !osc_wr && !sleep_exec
		|=> $stable(oscillator_control_register_q))
		else $error("control register changed while not ready");

	AST_SLEEP_EXIT: assert property (@(posedge clk) disable iff (rst)
		state_q == ST_FAILSAFE && sleep_exec |=>
		state_q != ST_FAILSAFE ##1 !on_primary)
		else $error("sleep did not clear fail-safe");

	AST_LATCH_CLR: assert property (@(posedge clk) disable iff (rst)
		sample_rise && !prim_fall |=> !clock_monitor_latch_q)
		else $error("sample edge did not clear latch");

	AST_FAIL_EFFECT: assert property (@(posedge clk) disable iff (rst)
		mon_active && sample_fall && clock_monitor_latch_q |=>
		wdt_rst_q && irq_stat_q[IRQ_FAIL_BIT] && state_q == ST_FAILSAFE)
		else $error("failure not acted on");

	AST_FAIL_CTRL: assert property (@(posedge clk) disable iff (rst)
		fail_det && !osc_wr |=> $stable(oscillator_control_register_q)
		##1 !on_primary)
		else $error("failure touched control register");

	AST_WDT_PULSE: assert property (@(posedge clk) disable iff (rst)
		wdt_rst_q |-> $past(fail_det) ##1 !wdt_rst_q)
		else $error("watchdog reset not a single pulse");

	AST_FAIL_CUT: assert property (@(posedge clk) disable iff (rst)
		fail_det |=> !on_primary)
		else $error("primary gate open after failure");

	AST_FS_RESTART: assert property (@(posedge clk) disable iff (rst)
		state_q == ST_FAILSAFE && sleep_exec && wants_primary |=>
		state_q == ST_START && !ost_done_q && !pll_done_q)
		else $error("sleep exit did not restart start-up");

	AST_READY_EVENT: assert property (@(posedge clk) disable iff (rst)
		state_q == ST_START && primary_ready && !sleep_exec |=>
		irq_stat_q[IRQ_READY_BIT])
		else $error("ready event not recorded");

endmodule : fscx_top

// ===== dv/fscx_tb.sv
// Self-checking bench for the fail-safe clock exit block
`timescale 1ns/1ns
module tb;
	import fscx_pkg::*;

	// Clock and reset
	logic        clk;
	logic        rst;
	// Wishbone
	logic        wb_cyc, wb_stb, wb_we, wb_ack;
	logic [7:0]  wb_adr;
	logic [3:0]  wb_sel;
	logic [31:0] wb_dat_w, wb_dat_r;
	// Sources, configuration and events
	logic        primary_clk, internal_oscillator_clock, internal_rc_clock;
	logic [1:0]  cfg_osc_mode;
	logic        cfg_monitor_en, sleep_exec, wake;
	// Outputs
	logic        sys_clk, on_primary, power_managed;
	logic        watchdog_counter_reset, irq;
	// Bench state
	logic [31:0] exp_q[$], msk_q[$];
	logic [2:0]  div_q;
	logic        prim_run, sys_prev;
	int          fail_count, n_tests, wd_cnt, sys_tog, seed, t0;
	logic [31:0] v;

	fscx_top #(.OST_COUNT(4), .PLL_CYCLES(4)) fscx_top_i (
		.clk(clk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
		.wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
		.wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
		.primary_clk(primary_clk),
		.internal_oscillator_clock(internal_oscillator_clock),
		.internal_rc_clock(internal_rc_clock),
		.cfg_osc_mode(cfg_osc_mode), .cfg_monitor_en(cfg_monitor_en),
		.sleep_exec(sleep_exec), .wake(wake), .sys_clk(sys_clk),
		.on_primary(on_primary), .power_managed(power_managed),
		.watchdog_counter_reset(watchdog_counter_reset), .irq(irq)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Source levels; the primary stands still when prim_run is low
	always @(posedge clk) begin
		div_q                     <= div_q + 3'h1;
		internal_rc_clock         <= ~internal_rc_clock;
		internal_oscillator_clock <= div_q[0];
		if (prim_run) begin
			primary_clk <= div_q[2];
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask : check

	// Result side: every ack retires the oldest note
	always @(posedge clk) begin
		sys_prev <= sys_clk;
		if (sys_prev !== sys_clk) begin
			sys_tog++;
		end
		if (watchdog_counter_reset === 1'b1) begin
			wd_cnt++;
		end
		if (wb_ack === 1'b1 && exp_q.size() > 0) begin
			if (msk_q[0] != 32'h0) begin
				check(wb_dat_r & msk_q[0], exp_q[0] & msk_q[0]);
			end
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
	end

	task automatic bus(input logic we, input logic [7:0] a,
		input logic [31:0] d, input logic [31:0] m, input logic [31:0] e);
		int n;
		n = 0;
		exp_q.push_back(e);
		msk_q.push_back(m);
		wb_cyc   <= 1'b1;
		wb_stb   <= 1'b1;
		wb_we    <= we;
		wb_adr   <= a;
		wb_dat_w <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		if (n == 50) begin
			check(32'h1, 32'h0);
		end
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk);
	endtask : bus

	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		bus(1'b0, a, 32'h0, m, e);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 32'h0, 32'h0);
	endtask : wr

	task automatic pulse(input bit slp);
		if (slp) sleep_exec <= 1'b1;
		else wake <= 1'b1;
		@(posedge clk);
		sleep_exec <= 1'b0;
		wake       <= 1'b0;
		@(posedge clk);
	endtask : pulse

	// Bounded wait for the primary gate to reach a level
	task automatic wait_prim(input logic lvl);
		int n;
		n = 0;
		while (on_primary !== lvl && n < 1000) begin
			@(posedge clk);
			n++;
		end
		check({31'h0, on_primary}, {31'h0, lvl});
		repeat (3) @(posedge clk);
	endtask : wait_prim

	task automatic rst_dut();
		rst <= 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
	endtask : rst_dut

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict

	initial begin
		#(40 * 60000);
		fail_count++;
		give_verdict();
	end

	initial begin
		seed = 32'heed3;
		{rst, wb_cyc, wb_stb, wb_we, sleep_exec, wake} = '0;
		{wb_adr, wb_sel, wb_dat_w, div_q, sys_prev} = '0;
		wb_sel = 4'hf;
		{primary_clk, internal_oscillator_clock, internal_rc_clock} = '0;
		{cfg_monitor_en, fail_count, n_tests, wd_cnt, sys_tog} = '0;
		cfg_osc_mode = MODE_XT;
		prim_run = 1'b1;
		rst = 1'b1;
		rst_dut();
		rd(ADDR_OSC_CTRL, 32'hff, 32'h0);
		check({31'h0, on_primary}, 32'h0);
		rd(ADDR_IRQ_CLR, 32'hffffffff, 32'h0);
		rd(8'h14, 32'hffffffff, 32'h0);
		wr(ADDR_IRQ_EN, 32'h3);
		rd(ADDR_IRQ_EN, 32'hffffffff, 32'h3);
		// A write without the low byte lane selected must be ignored
		wb_sel <= 4'he;
		wr(ADDR_IRQ_EN, 32'h0);
		wb_sel <= 4'hf;
		rd(ADDR_IRQ_EN, 32'hffffffff, 32'h3);
		wait_prim(1'b1);
		rd(ADDR_OSC_CTRL, 32'hff, 32'h08);
		rd(ADDR_IRQ_STAT, 32'h2, 32'h2);
		check({31'h0, irq}, 32'h1);
		wr(ADDR_IRQ_CLR, 32'h3);
		rd(ADDR_IRQ_STAT, 32'h3, 32'h0);
		check({31'h0, irq}, 32'h0);
		cfg_monitor_en <= 1'b1;
		wait_prim(1'b0);
		check(wd_cnt, 1);
		rd(ADDR_IRQ_STAT, 32'h1, 32'h1);
		rd(ADDR_OSC_CTRL, 32'hff, 32'h08);
		rd(ADDR_MON_STAT, 32'h5, 32'h1);
		check({31'h0, irq}, 32'h1);
		repeat (300) @(posedge clk);
		rd(ADDR_MON_STAT, 32'h5, 32'h1);
		// Leave through sleep with the primary selected and a random field
		cfg_monitor_en <= 1'b0;
		v = {25'h0, 3'($random(seed)), 4'h0};
		wr(ADDR_OSC_CTRL, v);
		pulse(1'b1);
		check({31'h0, power_managed}, 32'h1);
		rd(ADDR_MON_STAT, 32'h1, 32'h0);
		rd(ADDR_OSC_CTRL, 32'hff, v & 32'h73);
		pulse(1'b0);
		check({31'h0, power_managed}, 32'h0);
		wait_prim(1'b1);
		rd(ADDR_OSC_CTRL, 32'hff, (v & 32'h73) | 32'h08);
		cfg_monitor_en <= 1'b1;
		wait_prim(1'b0);
		check(wd_cnt, 2);
		wr(ADDR_OSC_CTRL, 32'h01);
		pulse(1'b1);
		rd(ADDR_MON_STAT, 32'h5, 32'h0);
		pulse(1'b0);
		cfg_monitor_en <= 1'b0;
		for (int m = 0; m < 4; m++) begin
			cfg_osc_mode <= 2'(m);
			rst_dut();
			rd(ADDR_OSC_CTRL, 32'hff, (m == 0) ? 32'h08 : 32'h0);
			wait_prim(1'b1);
			rd(ADDR_OSC_CTRL, 32'h08, 32'h08);
		end
		// Primary never starts
		prim_run <= 1'b0;
		cfg_osc_mode <= MODE_XT_PLL;
		rst_dut();
		repeat (500) @(posedge clk);
		rd(ADDR_OSC_CTRL, 32'hff, 32'h0);
		check({31'h0, on_primary}, 32'h0);
		t0 = sys_tog;
		repeat (40) @(posedge clk);
		check({31'h0, sys_tog > t0 + 10}, 32'h1);
		give_verdict();
	end
endmodule : tb
